/* File: srs_pkg.sv */
`default_nettype none
package srs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned RESET_MIN_NS = 1000000;
  // Least time, so round up to whole clock cycles
  localparam int unsigned RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_PULSE_CYCLES = 4;

  // ----------------------------------------------------------------
  // Widths and defaults
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 16;
  localparam int unsigned INIT_W = 3;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned SYNC_W = IRQ_W + 2;
  // Shared pins come out of any hard reset as test-select input and host-bus reset output
  localparam logic CS_MODE_DEFAULT = 1'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SEQ_OFF, SEQ_PWR_HOLD, SEQ_SW_HOLD, SEQ_RUN} srsSeq_t;
  typedef enum logic [1:0] {FL_IDLE, FL_FLUSH, FL_ACK} srsFlush_t;

  // Pin inputs after the synchroniser
  typedef struct packed {
    logic powerGood;
    logic shareN;
    logic [IRQ_W-1:0] irqN;
  } srsPins_t;

  typedef struct packed {
    srsSeq_t seq;
    logic [CNT_W-1:0] msCount;
    logic cpuReset;
    logic hostReset;
    logic busResetDrive;
    logic regDefault;
    logic csMode;
    logic [INIT_W-1:0] initCount;
    srsFlush_t flush;
    logic flushReq;
    logic ackActive;
    logic testActive;
    logic [IRQ_W-1:0] testSel;
  } srsState_t;

  localparam srsState_t STATE_RST = '{
    seq: SEQ_OFF,
    msCount: 16'h0000,
    cpuReset: 1'h1,
    hostReset: 1'h1,
    busResetDrive: 1'h1,
    regDefault: 1'h1,
    csMode: CS_MODE_DEFAULT,
    initCount: 3'h0,
    flush: FL_IDLE,
    flushReq: 1'h0,
    ackActive: 1'h0,
    testActive: 1'h0,
    testSel: 4'h0
  };

endpackage
`default_nettype wire

/* File: srs_sync2.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ------------------------------------------------------------------
module srs_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      syncOut <= '0;
    end else begin
      meta <= asyncIn;
      syncOut <= meta;
    end
  end

endmodule // srs_sync2
`default_nettype wire

/* File: srs_reset_sequencer.sv */
// Function
// - Power-good low holds CPU, host-bus and expansion-bus resets asserted.
// - Power-good high leads to release of all three reset outputs.
// - Power-good may change at any time relative to the clock.
// - CPU reset asserted at power-up and on software hard reset.
// - CPU reset changes launch from the rising clock edge.
// - Software hard reset returns internal registers to defaults.
// - Host-bus reset asserted at power-up and on software hard reset.
// - Host-bus reset released no earlier than 1 ms after power-good.
// - Software hard reset holds host-bus reset at least 1 ms.
// - Host-bus reset need not be timed to the clock.
// - Chip-select bit picks the function of both shared pins.
// - Shutdown special cycle asserts CPU init.
// - Software soft reset asserts CPU init.
// - Expansion-bus reset drive asserted at power-up and any hard reset.
// - Software hard reset holds expansion-bus reset drive at least 1 ms.
// - After hard reset the shared input pin is test-select.
// - Test-select combines with interrupt requests to choose test mode.
// - Acknowledge driven on rising edge, negated during host-bus reset.
// - Hard reset starts from power-good or software hard reset request.
`timescale 1ns/10ps
`default_nettype none
module srs_reset_sequencer import srs_pkg::*; #(
  parameter int unsigned MinResetCycles = RESET_MIN_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // Asynchronous power-good pin
  input wire logic power_good,
  // One-cycle request from the reset-control register: hard reset
  input wire logic hardResetReq,
  // One-cycle request from the reset-control register: soft reset
  input wire logic softResetReq,
  // One-cycle pulse: shutdown special cycle seen on the host bus
  input wire logic shutdownCycle,
  // Write strobe and value of the interrupt-controller chip-select bit
  input wire logic xbusCsWrite,
  input wire logic xbusCsData,
  // Shared pin: test_select_n or intc_flush_request_n
  input wire logic testSelectReqN,
  // Interrupt request pins, active low, used for test mode choice
  input wire logic [IRQ_W-1:0] irqN,
  // Buffers report that the flush has completed
  input wire logic flushDone,
  // Open-drain CPU reset pin
  output logic cpuResetOut,
  output logic cpuResetOe,
  // Shared pin: host_bus_reset_n or intc_flush_ack_n
  output logic hostBusResetAckN,
  output logic expansionBusResetDrive,
  // Open-drain CPU init pin
  output logic cpuInitOut,
  output logic cpuInitOe,
  // Level to the rest of the chip: hold registers at their defaults
  output logic registersDefault,
  // Flush request towards the DMA buffers
  output logic flushRequest,
  // Current chip-select bit value
  output logic intcChipSelect,
  // Test mode selection
  output logic testModeActive,
  output logic [IRQ_W-1:0] testModeSel
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  srsPins_t pins;
  logic [SYNC_W-1:0] pinsRaw;
  logic [SYNC_W-1:0] pinsSync;

  // All pins share one synchroniser; power-good is the one that matters
  assign pinsRaw = {power_good, testSelectReqN, irqN};
  assign pins = srsPins_t'(pinsSync);

  srs_sync2 #(
    .WIDTH(SYNC_W)
  ) uSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .asyncIn(pinsRaw),
    .syncOut(pinsSync)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  srsState_t s;
  srsState_t next_s;
  logic holdDone;
  logic flushReqSeen;
  logic initTrigger;
  logic [CNT_W-1:0] holdLast;

  // Terminal count of the 1 ms windows, cut to the counter width
  assign holdLast = CNT_W'(MinResetCycles - 1);
  assign holdDone = (s.msCount == holdLast);

  // Flush request only counts in acknowledge function
  assign flushReqSeen = s.csMode && !pins.shareN;

  // Init sources are ignored while a hard reset holds the CPU
  assign initTrigger = (shutdownCycle || softResetReq) && (s.seq == SEQ_RUN);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.regDefault = 1'h0;

    // Reset sequencing
    unique case (s.seq)
      SEQ_OFF: begin
        next_s.cpuReset = 1'h1;
        next_s.hostReset = 1'h1;
        next_s.busResetDrive = 1'h1;
        next_s.regDefault = 1'h1;
        next_s.msCount = '0;
        if (pins.powerGood) begin
          next_s.seq = SEQ_PWR_HOLD;
        end
      end
      SEQ_PWR_HOLD: begin
        // Window starts at power-good, so release waits at least 1 ms
        next_s.msCount = CNT_W'(s.msCount + 16'h0001);
        if (holdDone) begin
          next_s.seq = SEQ_RUN;
          next_s.cpuReset = 1'h0;
          next_s.hostReset = 1'h0;
          next_s.busResetDrive = 1'h0;
          next_s.msCount = '0;
        end
      end
      SEQ_SW_HOLD: begin
        next_s.msCount = CNT_W'(s.msCount + 16'h0001);
        if (holdDone) begin
          next_s.seq = SEQ_RUN;
          next_s.cpuReset = 1'h0;
          next_s.hostReset = 1'h0;
          next_s.busResetDrive = 1'h0;
          next_s.msCount = '0;
        end
      end
      SEQ_RUN: begin
        if (hardResetReq) begin
          next_s.seq = SEQ_SW_HOLD;
          next_s.cpuReset = 1'h1;
          next_s.hostReset = 1'h1;
          next_s.busResetDrive = 1'h1;
          next_s.regDefault = 1'h1;
          next_s.msCount = '0;
        end
      end
    endcase

    // Chip-select bit: software writes it only outside a hard reset
    if (xbusCsWrite && (s.seq == SEQ_RUN) && !hardResetReq) begin
      next_s.csMode = xbusCsData;
    end

    // CPU init pulse, restarted by each new trigger
    if (initTrigger && !hardResetReq) begin
      next_s.initCount = INIT_W'(INIT_PULSE_CYCLES);
    end else if (s.initCount != 3'h0) begin
      next_s.initCount = INIT_W'(s.initCount - 3'h1);
    end

    // Flush handshake in acknowledge function
    unique case (s.flush)
      FL_IDLE: begin
        if (flushReqSeen) begin
          next_s.flush = FL_FLUSH;
          next_s.flushReq = 1'h1;
        end
      end
      FL_FLUSH: begin
        if (flushDone) begin
          next_s.flush = FL_ACK;
          next_s.flushReq = 1'h0;
          next_s.ackActive = 1'h1;
        end
      end
      FL_ACK: begin
        // Acknowledge stands until the requester lets go
        if (!flushReqSeen) begin
          next_s.flush = FL_IDLE;
          next_s.ackActive = 1'h0;
        end
      end
      default: begin
        next_s.flush = FL_IDLE;
        next_s.flushReq = 1'h0;
        next_s.ackActive = 1'h0;
      end
    endcase

    // Test mode from test-select and the interrupt request pins
    next_s.testActive = !s.csMode && !pins.shareN && (s.seq == SEQ_RUN);
    next_s.testSel = next_s.testActive ? ~pins.irqN : 4'h0;

    // Any hard reset wipes the control state back to defaults
    if (next_s.regDefault || !pins.powerGood || next_s.hostReset) begin
      next_s.csMode = CS_MODE_DEFAULT;
      next_s.flush = FL_IDLE;
      next_s.flushReq = 1'h0;
      next_s.ackActive = 1'h0;
      next_s.testActive = 1'h0;
      next_s.testSel = 4'h0;
    end
    if (next_s.regDefault || !pins.powerGood) begin
      next_s.initCount = 3'h0;
    end

    // Power lost: every reset goes active at once, whatever the state
    if (!pins.powerGood) begin
      next_s.seq = SEQ_OFF;
      next_s.cpuReset = 1'h1;
      next_s.hostReset = 1'h1;
      next_s.busResetDrive = 1'h1;
      next_s.regDefault = 1'h1;
      next_s.msCount = '0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset comes up with all reset outputs asserted
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: pin floats high for asserted reset, pulled low otherwise
  assign cpuResetOut = 1'h0;
  assign cpuResetOe = !s.cpuReset;

  // The host-bus reset is launched from the clock although it may be
  // sampled without relation to it; this keeps the pin glitch free
  assign hostBusResetAckN = s.csMode ? !s.ackActive : !s.hostReset;

  assign expansionBusResetDrive = s.busResetDrive;

  // Init pin floats high while the pulse runs
  assign cpuInitOut = 1'h0;
  assign cpuInitOe = (s.initCount == 3'h0);

  assign registersDefault = s.regDefault;
  assign flushRequest = s.flushReq;
  assign intcChipSelect = s.csMode;
  assign testModeActive = s.testActive;
  assign testModeSel = s.testSel;

endmodule // srs_reset_sequencer
`default_nettype wire

/* File: srs_reset_sequencer_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module srs_reset_sequencer_sva import srs_pkg::*; #(
  parameter int unsigned MinResetCycles = RESET_MIN_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic power_good,
  input wire logic hardResetReq,
  input wire logic softResetReq,
  input wire logic shutdownCycle,
  input wire logic testSelectReqN,
  input wire logic [IRQ_W-1:0] irqN,
  input wire logic flushDone,
  input wire logic cpuResetOe,
  input wire logic hostBusResetAckN,
  input wire logic expansionBusResetDrive,
  input wire logic cpuInitOe,
  input wire logic registersDefault,
  input wire logic flushRequest,
  input wire logic intcChipSelect,
  input wire logic testModeActive,
  input wire logic [IRQ_W-1:0] testModeSel
);
  logic [CNT_W-1:0] holdCnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Length of the current reset-drive window, saturating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) holdCnt <= '0;
    else holdCnt <= expansionBusResetDrive ? holdCnt + CNT_W'(holdCnt != '1) : '0;
  end
  pg_low_a: assert property (!power_good [*4] |-> !cpuResetOe && expansionBusResetDrive)
    else $error("reset outputs free while power is bad");
  reset_pair_a: assert property (cpuResetOe != expansionBusResetDrive)
    else $error("cpu reset and bus reset drive disagree");
  host_mux_a: assert property (!intcChipSelect |-> hostBusResetAckN == cpuResetOe)
    else $error("host reset pin differs from cpu reset");
  hold_min_a: assert property ($fell(expansionBusResetDrive) |-> holdCnt >= MinResetCycles)
    else $error("reset window too short");
  hard_take_a: assert property (hardResetReq && cpuResetOe |=> !cpuResetOe
    && !hostBusResetAckN && registersDefault && !intcChipSelect)
    else $error("hard reset request not taken");
  reg_pulse_a: assert property (hardResetReq && cpuResetOe |=> ##1 !registersDefault)
    else $error("register default not a single cycle");
  init_pulse_a: assert property ((softResetReq || shutdownCycle) && cpuResetOe && !hardResetReq
    |=> !cpuInitOe [*4] ##1 cpuInitOe) else $error("init pulse length wrong");
  ack_neg_a: assert property (!cpuResetOe |-> !flushRequest && !intcChipSelect)
    else $error("flush active during host reset");
  flush_ack_a: assert property (intcChipSelect && flushRequest && flushDone && cpuResetOe
    && !hardResetReq |=> !flushRequest && !hostBusResetAckN) else $error("no flush ack");
  test_sel_a: assert property ((cpuResetOe && !intcChipSelect && !testSelectReqN) [*4]
    |-> testModeActive && testModeSel == ~$past(irqN, 3)) else $error("test mode select wrong");
  // Main scenarios reached
  cover property ($rose(cpuResetOe));
  cover property ($fell(cpuInitOe));
  cover property (intcChipSelect && $fell(hostBusResetAckN));
endmodule // srs_reset_sequencer_sva
bind srs_reset_sequencer srs_reset_sequencer_sva #(.MinResetCycles(MinResetCycles)) sva_i (
  .core_clk(core_clk), .rst_n(rst_n), .power_good(power_good), .hardResetReq(hardResetReq),
  .softResetReq(softResetReq), .shutdownCycle(shutdownCycle), .testSelectReqN(testSelectReqN),
  .irqN(irqN), .flushDone(flushDone), .cpuResetOe(cpuResetOe), .cpuInitOe(cpuInitOe),
  .hostBusResetAckN(hostBusResetAckN), .expansionBusResetDrive(expansionBusResetDrive),
  .registersDefault(registersDefault), .flushRequest(flushRequest),
  .intcChipSelect(intcChipSelect), .testModeActive(testModeActive), .testModeSel(testModeSel));
`default_nettype wire

/* File: srs_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
module srs_far_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic askFlush,
  input wire logic slow,
  input wire logic flushRequest,
  input wire logic hostBusResetAckN,
  output logic reqN,
  output logic flushDone
);
  logic [2:0] waitCnt;
  // Request held until ack, then released to the pull-up level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reqN <= 1'h1;
      flushDone <= 1'h0;
      waitCnt <= 3'h0;
    end else begin
      if (askFlush) reqN <= 1'h0;
      else if (!hostBusResetAckN) reqN <= 1'h1;
      flushDone <= flushRequest && !flushDone && waitCnt >= (slow ? 3'h5 : 3'h0);
      waitCnt <= (flushRequest && !flushDone) ? waitCnt + 3'h1 : 3'h0;
    end
  end
endmodule // srs_far_model
`default_nettype wire

/* File: test_system_reset_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module test_system_reset_sequencer import srs_pkg::*;;
  localparam int unsigned MIN = 20;
  logic core_clk, rst_n, power_good, hardResetReq, softResetReq, shutdownCycle;
  logic xbusCsWrite, xbusCsData, tbTestN, askFlush, slow, reqN, flushDone, testSelectReqN;
  logic cpuResetOut, cpuResetOe, hostBusResetAckN, expansionBusResetDrive, cpuInitOut;
  logic cpuInitOe, registersDefault, flushRequest, intcChipSelect, testModeActive;
  logic [IRQ_W-1:0] irqN, testModeSel;
  logic [11:0] obs;
  logic [11:0] expQ[$];
  int fails = 0;
  int testsRun = 0;
  event smp;
  // Shared pin: far side drives it only in flush mode
  assign testSelectReqN = intcChipSelect ? reqN : tbTestN;
  assign obs = {cpuResetOe, hostBusResetAckN, expansionBusResetDrive, cpuInitOe, registersDefault,
    flushRequest, intcChipSelect, testModeActive, testModeSel};
  srs_reset_sequencer #(.MinResetCycles(MIN)) srs_reset_sequencer_i (
    .core_clk(core_clk), .rst_n(rst_n), .power_good(power_good), .hardResetReq(hardResetReq),
    .softResetReq(softResetReq), .shutdownCycle(shutdownCycle), .xbusCsWrite(xbusCsWrite),
    .xbusCsData(xbusCsData), .testSelectReqN(testSelectReqN), .irqN(irqN), .flushDone(flushDone),
    .cpuResetOut(cpuResetOut), .cpuResetOe(cpuResetOe), .hostBusResetAckN(hostBusResetAckN),
    .expansionBusResetDrive(expansionBusResetDrive), .cpuInitOut(cpuInitOut),
    .cpuInitOe(cpuInitOe), .registersDefault(registersDefault), .flushRequest(flushRequest),
    .intcChipSelect(intcChipSelect), .testModeActive(testModeActive), .testModeSel(testModeSel));
  srs_far_model srs_far_model_i (.core_clk(core_clk), .rst_n(rst_n), .askFlush(askFlush),
    .slow(slow), .flushRequest(flushRequest), .hostBusResetAckN(hostBusResetAckN),
    .reqN(reqN), .flushDone(flushDone));
  // Clock
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic note(input logic [11:0] e);
    expQ.push_back(e);
    ->smp;
  endtask
  task automatic check(input logic [11:0] s, input logic [11:0] e);
    testsRun++;
    if (s !== e) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick();
    s = 1'h0;
  endtask
  // Bounded wait; a miss shows up in the following comparison
  task automatic poll(ref logic s, input logic v);
    for (int i = 0; i < 40 && s !== v; i++) tick();
  endtask
  task automatic end_sim;
    if (fails == 0 && testsRun > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Monitor: oldest note against what the outputs show
  initial forever begin
    @smp;
    check(obs, expQ.pop_front());
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (4000) @(posedge core_clk);
    fails++;
    end_sim;
  end
  // Main sequence
  initial begin
    {rst_n, power_good, hardResetReq, softResetReq, shutdownCycle} = 5'h0;
    {xbusCsWrite, xbusCsData, askFlush, slow} = 4'h0;
    tbTestN = 1'h1;
    irqN = '1;
    void'($urandom(32'hb19f));
    tick(4);
    note(12'h380);
    tick(4);
    rst_n = 1'h1;
    tick(10);
    note(12'h380);
    power_good = 1'h1;
    tick(MIN + 2);
    note(12'h300);
    poll(cpuResetOe, 1'h1);
    note(12'hd00);
    xbusCsData = 1'h1;
    pulse(xbusCsWrite);
    note(12'hd20);
    pulse(hardResetReq);
    poll(cpuResetOe, 1'h0);
    note(12'h380);
    tick(MIN - 2);
    note(12'h300);
    poll(cpuResetOe, 1'h1);
    note(12'hd00);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) pulse(softResetReq);
      else pulse(shutdownCycle);
      poll(cpuInitOe, 1'h0);
      note(12'hc00);
      tick(3);
      note(12'hc00);
      tick();
      note(12'hd00);
    end
    pulse(xbusCsWrite);
    for (int k = 0; k < 2; k++) begin
      slow = (k == 1);
      pulse(askFlush);
      poll(flushRequest, 1'h1);
      note(12'hd60);
      poll(hostBusResetAckN, 1'h0);
      note(12'h920);
      poll(hostBusResetAckN, 1'h1);
      note(12'hd20);
    end
    xbusCsData = 1'h0;
    pulse(xbusCsWrite);
    for (int k = 0; k < 4; k++) begin
      irqN = IRQ_W'($urandom);
      tbTestN = 1'h0;
      tick(4);
      note({8'hd1, ~irqN});
      tbTestN = 1'h1;
      tick(4);
      note(12'hd00);
    end
    power_good = 1'h0;
    tick(4);
    note(12'h380);
    tick(2);
    // Open-drain data pins never carry anything but the low level
    check({10'h000, cpuResetOut, cpuInitOut}, 12'h000);
    end_sim;
  end
endmodule // test_system_reset_sequencer
`default_nettype wire
